// ---- gac_params.svh ----
`ifndef GAC_PARAMS_SVH
`define GAC_PARAMS_SVH
`define OP_DRAW_LINE     8'h21
`define OP_DRAW_RECT     8'h22
`define OP_COPY          8'h23
`define OP_DIM_WIN       8'h24
`define OP_CLEAR_WIN     8'h25
`define OP_FILL_CFG      8'h26
`define OP_PRECHARGE     8'hbb
`define OP_COM_DESELECT  8'hbe
`define OP_OTP_WRITE     8'hc0
`define OP_DISP_RESET    8'he2
`define OP_NOP           8'he3
`define OP_LOCK          8'hfd
`define NPAR_LINE        4'h7
`define NPAR_RECT        4'ha
`define NPAR_COPY        4'h6
`define NPAR_WIN         4'h4
`define NPAR_ONE         4'h1
`define RST_PRECHARGE    8'h3e
`define RST_COM_DESEL    8'h3c
`define RST_LOCK_PARAM   8'h12
`define LOCK_BIT         2
`define FILL_BIT         0
`define REVCOPY_BIT      4
`define DIM_KEEP_MAX     6'h0f
`define DIM_BASE         6'h04
`endif

// ---- gac_pkg.sv ----
`default_nettype none
package gac_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_PARM = 6'b000010,
		ST_LINE = 6'b000100,
		ST_RECT = 6'b001000,
		ST_COPY = 6'b010000,
		ST_WIN  = 6'b100000
	} eng_state_t;
	typedef logic [5:0] color_t;
	typedef logic [7:0] coord_t;
endpackage : gac_pkg
`default_nettype wire

// ---- graphic_accel_command_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gac_params.svh"
module graphic_accel_command_engine #(
	parameter int COLS = 160,
	parameter int ROWS = 132
) (
	input  wire logic           clk_sys,
	input  wire logic           resetn,
	input  wire logic           byte_valid,
	input  wire logic           dc_data,
	input  wire logic [7:0]     byte_in,
	output logic                mem_access_ok,
	output logic                busy,
	output logic [7:0]          mem_col,
	output logic [7:0]          mem_row,
	output logic                mem_we,
	output logic [17:0]         mem_wdata,
	output logic                mem_re,
	input  wire logic [17:0]    mem_rdata,
	output logic [4:0]          precharge_level,
	output logic [3:0]          com_deselect_level,
	output logic                otp_write,
	output logic [3:0]          color_b_trim,
	output logic [3:0]          color_a_trim,
	output logic                disp_reset,
	output logic                port_locked,
	output logic                fill_enable,
	output logic                reverse_copy
);
	import gac_pkg::*;

	// Coordinates are eight bits wide, so larger panels cannot be addressed
	if (COLS < 1 || COLS > 256 || ROWS < 1 || ROWS > 256) begin : g_bad_size
		$error("Display size out of 8-bit coordinate range");
	end

	typedef struct packed {
		eng_state_t  st;
		logic [7:0]  op;
		logic [3:0]  pcnt;
		logic [3:0]  pneed;
		coord_t [9:0] par;
		logic [7:0]  prech;
		logic [7:0]  comd;
		logic [7:0]  lockp;
		logic [7:0]  fillp;
		logic        otp;
		logic [7:0]  trim;
		logic        drst;
		coord_t      x;
		coord_t      y;
		logic        we;
		logic [17:0] wd;
		logic        rph;
		logic [7:0]  ci;
		logic [7:0]  ri;
		logic signed [9:0] err;
		logic [17:0] held;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// Parameter count per opcode; zero means single-byte command, except OTP write, whose count is forced to one at decode
	function automatic logic [3:0] par_count(input logic [7:0] op);
		unique case (op)
			`OP_DRAW_LINE:                          par_count = `NPAR_LINE;
			`OP_DRAW_RECT:                          par_count = `NPAR_RECT;
			`OP_COPY:                               par_count = `NPAR_COPY;
			`OP_DIM_WIN, `OP_CLEAR_WIN:             par_count = `NPAR_WIN;
			`OP_FILL_CFG, `OP_PRECHARGE,
			`OP_COM_DESELECT, `OP_LOCK:             par_count = `NPAR_ONE;
			default:                                par_count = 4'h0;
		endcase
	endfunction : par_count

	// Dim one six-bit component: 0..15 kept, higher groups of four fold down
	function automatic color_t dim_step(input color_t gray_step);
		if (gray_step <= `DIM_KEEP_MAX)
			dim_step = gray_step;
		else
			dim_step = {2'b00, gray_step[5:2]} + `DIM_BASE - 6'h04;
	endfunction : dim_step

	function automatic logic [17:0] dim_pixel(input logic [17:0] p);
		dim_pixel = {dim_step(p[17:12]), dim_step(p[11:6]), dim_step(p[5:0])};
	endfunction : dim_pixel

	// Absolute difference of two coordinates
	function automatic logic [7:0] adiff(input coord_t a, input coord_t b);
		adiff = (a > b) ? a - b : b - a;
	endfunction : adiff

	logic locked;
	logic accept;
	logic [3:0] np;
	logic on_edge;
	logic [7:0] dx;
	logic [7:0] dy;
	logic signed [9:0] e2;

	assign locked = s_reg.lockp[`LOCK_BIT];
	assign np = par_count(byte_in);
	assign dx = adiff(s_reg.par[2], s_reg.par[0]);
	assign dy = adiff(s_reg.par[3], s_reg.par[1]);
	assign e2 = s_reg.err <<< 1;
	assign on_edge = (s_reg.x == s_reg.par[0]) || (s_reg.x == s_reg.par[2]) ||
		(s_reg.y == s_reg.par[1]) || (s_reg.y == s_reg.par[3]);

	// Command decode, parameter collection and drawing engine
	always_comb begin
		s_next = s_reg;
		s_next.otp = 1'b0;
		s_next.drst = 1'b0;
		s_next.we = 1'b0;
		accept = byte_valid && (!locked || (!dc_data && byte_in == `OP_LOCK) ||
			(dc_data && s_reg.st == ST_PARM && s_reg.op == `OP_LOCK));
		if (accept && !dc_data) begin
			// A new accepted opcode restarts the collector
			s_next.op = byte_in;
			s_next.pcnt = 4'h0;
			s_next.pneed = np;
			s_next.st = (np != 4'h0) ? ST_PARM : ST_IDLE;
			if (byte_in == `OP_DISP_RESET) begin
				s_next.drst = 1'b1;
				s_next.st = ST_IDLE;
			end
			if (byte_in == `OP_OTP_WRITE)
				s_next.st = ST_PARM;
			if (byte_in == `OP_OTP_WRITE)
				s_next.pneed = `NPAR_ONE;
		end else begin
			unique case (s_reg.st)
				ST_IDLE: begin
				end
				ST_PARM: begin
					if (accept && dc_data) begin
						s_next.par[s_reg.pcnt] = byte_in;
						s_next.pcnt = s_reg.pcnt + 4'h1;
						if (s_reg.pcnt + 4'h1 == s_reg.pneed) begin
							s_next.st = ST_IDLE;
							s_next.x = s_reg.par[0];
							s_next.y = s_reg.par[1];
							s_next.rph = 1'b1;
							unique case (s_reg.op)
								`OP_PRECHARGE:    s_next.prech = byte_in;
								`OP_COM_DESELECT: s_next.comd = byte_in;
								`OP_LOCK:         s_next.lockp = byte_in;
								`OP_FILL_CFG:     s_next.fillp = byte_in;
								`OP_OTP_WRITE: begin
									s_next.trim = byte_in;
									s_next.otp = 1'b1;
								end
								`OP_DRAW_LINE: begin
									s_next.st = ST_LINE;
									s_next.err = $signed({2'b00, dx}) - $signed({2'b00, dy});
								end
								`OP_DRAW_RECT: s_next.st = ST_RECT;
								`OP_COPY: begin
									s_next.st = ST_COPY;
									s_next.ci = 8'h00;
									s_next.ri = 8'h00;
								end
								default: s_next.st = ST_WIN;
							endcase
						end
					end
				end
				ST_LINE: begin
					// Bresenham walk, one pixel per clock
					s_next.we = 1'b1;
					s_next.wd = {s_reg.par[4][5:0], s_reg.par[5][5:0], s_reg.par[6][5:0]};
					if (s_reg.x == s_reg.par[2] && s_reg.y == s_reg.par[3])
						s_next.st = ST_IDLE;
					if (e2 > -$signed({2'b00, dy})) begin
						s_next.err = s_reg.err - $signed({2'b00, dy});
						s_next.x = (s_reg.par[2] > s_reg.x) ? s_reg.x + 8'h01 : s_reg.x - 8'h01;
					end
					if (e2 < $signed({2'b00, dx})) begin
						s_next.err = s_next.err + $signed({2'b00, dx});
						s_next.y = (s_reg.par[3] > s_reg.y) ? s_reg.y + 8'h01 : s_reg.y - 8'h01;
					end
				end
				ST_RECT, ST_WIN: begin
					// Raster walk; dim uses a read phase then a write phase
					if (s_reg.st == ST_WIN && s_reg.op == `OP_DIM_WIN && s_reg.rph) begin
						// A pending write owns the address bus, so the read waits a clock
						s_next.rph = s_reg.we;
					end else begin
						s_next.rph = 1'b1;
						s_next.we = 1'b1;
						if (s_reg.st == ST_RECT)
							s_next.we = on_edge || s_reg.fillp[`FILL_BIT];
						if (s_reg.st == ST_RECT)
							s_next.wd = on_edge ?
								{s_reg.par[4][5:0], s_reg.par[5][5:0], s_reg.par[6][5:0]} :
								{s_reg.par[7][5:0], s_reg.par[8][5:0], s_reg.par[9][5:0]};
						else if (s_reg.op == `OP_DIM_WIN)
							s_next.wd = dim_pixel(mem_rdata);
						else
							s_next.wd = 18'h00000;
						if (s_reg.x == s_reg.par[2]) begin
							s_next.x = s_reg.par[0];
							s_next.y = s_reg.y + 8'h01;
							if (s_reg.y == s_reg.par[3])
								s_next.st = ST_IDLE;
						end else begin
							s_next.x = s_reg.x + 8'h01;
						end
					end
				end
				ST_COPY: begin
					// Read source pixel, then write it at the offset target
					if (s_reg.rph) begin
						s_next.rph = s_reg.we; // Read waits while a write holds the bus
					end else begin
						s_next.rph = 1'b1;
						s_next.we = 1'b1;
						s_next.wd = mem_rdata;
						if (s_reg.ci == adiff(s_reg.par[2], s_reg.par[0])) begin
							s_next.ci = 8'h00;
							s_next.ri = s_reg.ri + 8'h01;
							if (s_reg.ri == adiff(s_reg.par[3], s_reg.par[1]))
								s_next.st = ST_IDLE;
						end else begin
							s_next.ci = s_reg.ci + 8'h01;
						end
					end
				end
				default: s_next.st = ST_IDLE;
			endcase
		end
	end

	// Registered state; reset gives the documented parameter values
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.prech <= `RST_PRECHARGE;
			s_reg.comd <= `RST_COM_DESEL;
			s_reg.lockp <= `RST_LOCK_PARAM;
			s_reg.rph <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Reverse copy walks from the far corner so overlapping moves stay intact
	logic [7:0] cp_col;
	logic [7:0] cp_row;
	always_comb begin
		cp_col = s_reg.fillp[`REVCOPY_BIT] ? adiff(s_reg.par[2], s_reg.par[0]) - s_reg.ci :
			s_reg.ci;
		cp_row = s_reg.fillp[`REVCOPY_BIT] ? adiff(s_reg.par[3], s_reg.par[1]) - s_reg.ri :
			s_reg.ri;
	end

	// Memory port: write address lags one cycle behind the walk
	logic [7:0] wcol_reg;
	logic [7:0] wrow_reg;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wcol_reg <= 8'h00;
			wrow_reg <= 8'h00;
		end else begin
			wcol_reg <= (s_reg.st == ST_COPY) ? s_reg.par[4] + cp_col : s_reg.x;
			wrow_reg <= (s_reg.st == ST_COPY) ? s_reg.par[5] + cp_row : s_reg.y;
		end
	end

	assign mem_re = (s_reg.st == ST_COPY || (s_reg.st == ST_WIN && s_reg.op == `OP_DIM_WIN))
		&& s_reg.rph && !s_reg.we;
	assign mem_col = s_reg.we ? wcol_reg :
		(s_reg.st == ST_COPY ? s_reg.par[0] + cp_col : s_reg.x);
	assign mem_row = s_reg.we ? wrow_reg :
		(s_reg.st == ST_COPY ? s_reg.par[1] + cp_row : s_reg.y);
	assign mem_we = s_reg.we;
	assign mem_wdata = s_reg.wd;
	assign busy = s_reg.st inside {ST_LINE, ST_RECT, ST_COPY, ST_WIN};
	assign mem_access_ok = !locked;
	assign precharge_level = s_reg.prech[5:1];
	assign com_deselect_level = s_reg.comd[5:2];
	assign otp_write = s_reg.otp;
	assign color_b_trim = s_reg.trim[7:4];
	assign color_a_trim = s_reg.trim[3:0];
	assign disp_reset = s_reg.drst;
	assign port_locked = locked;
	assign fill_enable = s_reg.fillp[`FILL_BIT];
	assign reverse_copy = s_reg.fillp[`REVCOPY_BIT];

	sequence s_lock_cmd;
		byte_valid && !dc_data && byte_in == `OP_LOCK;
	endsequence
	sequence s_lock_par;
		byte_valid && dc_data;
	endsequence

	a_reset_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
		(byte_valid && !dc_data && byte_in == `OP_DISP_RESET && !locked) |=>
		(!busy && disp_reset)) else $error("Display reset did not abort");
	a_lock_ignore: assert property (@(posedge clk_sys) disable iff (!resetn)
		(locked && byte_valid && !dc_data && byte_in != `OP_LOCK) |=>
		$stable(s_reg.op)) else $error("Command taken while locked");
	a_lock_set: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_lock_cmd ##1 (s_lock_par and byte_in[`LOCK_BIT]) |=> port_locked)
		else $error("Lock bit not applied");
	a_prech_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		(byte_valid && !dc_data && byte_in == `OP_PRECHARGE && !locked) ##1
		(byte_valid && dc_data) |=> precharge_level == $past(byte_in[5:1]))
		else $error("Pre-charge level not loaded");
	a_comd_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		(byte_valid && !dc_data && byte_in == `OP_COM_DESELECT && !locked) ##1
		(byte_valid && dc_data) |=> com_deselect_level == $past(byte_in[5:2]))
		else $error("Deselect level not loaded");
	a_otp_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
		otp_write |=> !otp_write) else $error("OTP strobe longer than one cycle");
	a_clear_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mem_we && s_reg.op == `OP_CLEAR_WIN) |-> mem_wdata == 18'h00000)
		else $error("Clear wrote nonzero data");
	a_fill_cfg: assert property (@(posedge clk_sys) disable iff (!resetn)
		(byte_valid && !dc_data && byte_in == `OP_FILL_CFG && !locked) ##1
		(byte_valid && dc_data) |=> fill_enable == $past(byte_in[0]) &&
		reverse_copy == $past(byte_in[4])) else $error("Fill config not loaded");
	a_dim_range: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mem_we && s_reg.op == `OP_DIM_WIN) |-> mem_wdata[5:0] <= `DIM_KEEP_MAX)
		else $error("Dim result above fifteen");
	a_port_exclusive: assert property (@(posedge clk_sys) disable iff (!resetn)
		mem_we |-> !mem_re) else $error("Read and write share one address cycle");
endmodule : graphic_accel_command_engine
`default_nettype wire

// ---- graphic_accel_command_engine_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module graphic_accel_command_engine_bench;
	import gac_pkg::*;
	typedef struct {
		logic [7:0] op;
		logic [7:0] par;
		logic [4:0] pre;
		logic [3:0] com;
		logic [1:0] fr;
	} row_t;
	logic        clk_sys;
	logic        resetn;
	logic        byte_valid;
	logic        dc_data;
	logic        mem_access_ok;
	logic        busy;
	logic        mem_we;
	logic        mem_re;
	logic        otp_write;
	logic        disp_reset;
	logic [7:0]  byte_in;
	logic [7:0]  mem_col;
	logic [7:0]  mem_row;
	logic [7:0]  ix;
	logic [17:0] mem_wdata;
	logic [17:0] mem_rdata;
	logic [17:0] mem [256];
	logic [4:0]  precharge_level;
	logic [3:0]  com_deselect_level;
	logic [3:0]  color_b_trim;
	logic [3:0]  color_a_trim;
	logic        port_locked;
	logic        fill_enable;
	logic        reverse_copy;
	logic [19:0] st;
	int num_errors = 0, checks_done = 0, n_otp = 0, n_disp = 0;
	row_t rows[9] = '{'{8'hc0, 8'ha5, 5'h1f, 4'hf, 2'b00}, '{8'hbb, 8'h00, 5'h00, 4'hf, 2'b00},
		'{8'hbb, 8'h14, 5'h0a, 4'hf, 2'b00}, '{8'hbb, 8'h3e, 5'h1f, 4'hf, 2'b00},
		'{8'hbe, 8'h00, 5'h1f, 4'h0, 2'b00}, '{8'hbe, 8'h1c, 5'h1f, 4'h7, 2'b00},
		'{8'hbe, 8'h3c, 5'h1f, 4'hf, 2'b00}, '{8'h26, 8'h11, 5'h1f, 4'hf, 2'b11},
		'{8'h26, 8'h00, 5'h1f, 4'hf, 2'b00}};

	always #5 clk_sys = ~clk_sys;
	assign ix = {mem_row[3:0], mem_col[3:0]};
	assign st = {precharge_level, com_deselect_level, color_b_trim, color_a_trim, fill_enable,
		reverse_copy, port_locked};

	host_model h (.clk_sys(clk_sys), .byte_valid(byte_valid), .dc_data(dc_data), .byte_in(byte_in));

	graphic_accel_command_engine i_dut (.clk_sys(clk_sys), .resetn(resetn),
		.byte_valid(byte_valid), .dc_data(dc_data), .byte_in(byte_in),
		.mem_access_ok(mem_access_ok), .busy(busy), .mem_col(mem_col), .mem_row(mem_row),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.precharge_level(precharge_level), .com_deselect_level(com_deselect_level),
		.otp_write(otp_write), .color_b_trim(color_b_trim), .color_a_trim(color_a_trim),
		.disp_reset(disp_reset), .port_locked(port_locked), .fill_enable(fill_enable),
		.reverse_copy(reverse_copy));

	// Sync display memory; data off a read cycle flips every clock, so a stale word matches again only every second cycle
	always @(posedge clk_sys) begin
		if (mem_we === 1'b1)
			mem[ix] <= mem_wdata;
		mem_rdata <= (mem_re === 1'b1) ? mem[ix] : ~mem_rdata;
		if (otp_write === 1'b1)
			n_otp++;
		if (disp_reset === 1'b1)
			n_disp++;
	end

	task chk(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [19:0] px(input int c, input int r);
		return {2'b00, mem[r * 16 + c]};
	endfunction : px

	// Bounded wait, so a stuck busy shows as a mismatch instead of a hang
	task wait_done;
		int n;
		n = 0;
		repeat (3) @(posedge clk_sys);
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		chk(20'(n < 2000), 20'h1);
		#1;
	endtask : wait_done

	task wrap_up;
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#300us;
		num_errors++;
		wrap_up();
	end

	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		mem_rdata = 18'h00000;
		for (int i = 0; i < 256; i++)
			mem[i] = 18'(i);
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		chk({precharge_level, com_deselect_level, fill_enable, reverse_copy, port_locked},
			{5'h1f, 4'hf, 3'b000});
		$display("test reset done");
		foreach (rows[i]) begin
			h.q = '{rows[i].par};
			h.run(rows[i].op);
			wait_done();
			chk(st, {rows[i].pre, rows[i].com, 8'ha5, rows[i].fr, 1'b0});
		end
		chk(20'(n_otp), 20'h1);
		$display("test settings done");
		// Locked port takes nothing but the lock opcode
		h.q = '{8'h04};
		h.run(8'hfd);
		wait_done();
		chk({port_locked, mem_access_ok}, 20'h2);
		h.q = '{8'h00};
		h.run(8'hbb);
		h.q = '{8'h00, 8'h00, 8'h03, 8'h03};
		h.run(8'h25);
		wait_done();
		chk({precharge_level, 3'b000, busy}, {5'h1f, 3'b000, 1'b0});
		chk(px(1, 1), 20'h11);
		h.q = '{8'h00};
		h.run(8'hfd);
		wait_done();
		chk({port_locked, mem_access_ok}, 20'h1);
		$display("test lock done");
		h.q = '{8'h00, 8'h04, 8'h03, 8'h04, 8'hff, 8'h2a, 8'h15};
		h.run(8'h21);
		wait_done();
		for (int c = 0; c < 4; c++)
			chk(px(c, 4), {2'b00, 6'h3f, 6'h2a, 6'h15});
		chk(px(4, 4), 20'h44);
		h.q = '{8'h01};
		h.run(8'h26);
		h.q = '{8'h01, 8'h08, 8'h03, 8'h0a, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
		h.run(8'h22);
		wait_done();
		chk(px(1, 8), {2'b00, 6'h01, 6'h02, 6'h03});
		chk(px(3, 10), {2'b00, 6'h01, 6'h02, 6'h03});
		chk(px(2, 9), {2'b00, 6'h04, 6'h05, 6'h06});
		// Mid-run reset must drop the fill enable set just above
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		chk({fill_enable, reverse_copy, port_locked, busy}, 20'h0);
		h.q = '{8'h00};
		h.run(8'h26);
		h.q = '{8'h00, 8'h04, 8'h01, 8'h04, 8'h06, 8'h06};
		h.run(8'h23);
		wait_done();
		chk(px(6, 6), {2'b00, 6'h3f, 6'h2a, 6'h15});
		chk(px(7, 6), {2'b00, 6'h3f, 6'h2a, 6'h15});
		mem[26] = {6'd63, 6'd16, 6'd15};
		h.q = '{8'h0a, 8'h01, 8'h0a, 8'h01};
		h.run(8'h24);
		wait_done();
		chk(px(10, 1), {2'b00, 6'd15, 6'd4, 6'd15});
		h.q = '{8'h00, 8'h04, 8'h02, 8'h04};
		h.run(8'h25);
		wait_done();
		for (int c = 0; c < 3; c++)
			chk(px(c, 4), 20'h0);
		chk(px(3, 4), {2'b00, 6'h3f, 6'h2a, 6'h15});
		// Overlapping shift right only survives when walked from the far corner
		h.q = '{8'h10};
		h.run(8'h26);
		h.q = '{8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
		h.run(8'h23);
		wait_done();
		chk(px(4, 4), {2'b00, 6'h3f, 6'h2a, 6'h15});
		chk(px(5, 4), 20'h44);
		$display("test drawing done");
		// Full-screen clear cut short by the display reset opcode
		h.q = '{8'h00, 8'h00, 8'h0f, 8'h0f};
		h.run(8'h25);
		repeat (3) @(posedge clk_sys);
		h.run(8'he2);
		wait_done();
		chk({busy, 7'h0, n_disp[11:0]}, 20'h1);
		chk(px(15, 15), 20'hff);
		$display("test abort done");
		wrap_up();
	end
endmodule : graphic_accel_command_engine_bench
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the byte port: one opcode, then its queued parameters
module host_model (
	input  wire logic       clk_sys,
	output logic            byte_valid,
	output logic            dc_data,
	output logic [7:0]      byte_in
);
	logic [7:0] q[$];

	// Idle port at time zero
	initial begin
		byte_valid = 1'b0;
		dc_data = 1'b0;
		byte_in = 8'h00;
	end

	// Bytes go back to back; the bus is scrambled once released
	task run(input logic [7:0] op);
		@(posedge clk_sys);
		byte_valid <= 1'b1;
		dc_data <= 1'b0;
		byte_in <= op;
		while (q.size() > 0) begin
			@(posedge clk_sys);
			dc_data <= 1'b1;
			byte_in <= q.pop_front();
		end
		@(posedge clk_sys);
		byte_valid <= 1'b0;
		byte_in <= ~byte_in;
	endtask : run
endmodule : host_model
`default_nettype wire
